// ### hw/spi_core_cfg.svh
// How it works
// R1: Core runs as bus master or as slave, chosen by a control bit.
// R2: Serial clock is driven when master, received from outside when slave.
// R3: MISO is sampled when master and driven when slave.
// R4: MOSI is driven when master and received when slave.
// R5: Master drives a primary select output toward an external peripheral.
// R6: Master has seven more select outputs, eight selectable slaves in all.
// R7: Slave accepts a select input that the external master asserts.
// R8: Active-low flash select routes slave transfers to the user flash port.
// R9: Clock polarity and phase are programmable: idle level and sample edge.
// R10: Each byte shifts least or most significant bit first, as selected.
// R11: Mode fault sets an error flag and can raise the interrupt output.
// R12: Fabric reaches control, status and data over an 8-bit WISHBONE slave.
// R13: Standby and wake requests go out only when wake-up is enabled.
// R14: Full-duplex byte transfers; data path is buffered so next byte waits.
// R15: Master seeing its select driven low faults and stops driving lines.
`ifndef SPI_CORE_CFG_SVH
`define SPI_CORE_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADR_CTRL 3'h0
`define ADR_DIV  3'h1
`define ADR_SEL  3'h2
`define ADR_STAT 3'h3
`define ADR_DATA 3'h4
`define ADR_PWR  3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ST_TX_READY 0
`define ST_RX_FULL  1
`define ST_MODF     2
`define ST_OVERRUN  3
`define ST_BUSY     4
`define PWR_STDBY   0
`define PWR_WAKE    1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CTRL_RST   7'h00
`define DIV_RST    8'h03
`define SEL_RST    8'h01
`define PINS_RST   5'h1b
`define IDLE_BYTE  8'hff
`define LAST_EDGE  4'hf
`define FIFO_DEPTH 4

`endif

// ### hw/spi_core_pkg.sv
package spi_core_pkg;

   // Control register layout, bit 0 at the bottom
   typedef struct packed {
      logic wake_en;
      logic irq_en;
      logic lsb_first;
      logic cpha;
      logic cpol;
      logic master;
      logic enable;
   } ctrl_t;

   // Synchronised pin levels
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic miso;
      logic scsn;
      logic ufm_n;
   } pins_t;

   typedef enum logic [1:0] {
      IDLE,
      ACTIVE,
      DONE
   } xfer_state_t;

endpackage : spi_core_pkg

// ### hw/spi_byte_fifo.sv
`timescale 1ns/1ps
module spi_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
      $error("spi_byte_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_ff @(posedge clk_sys_i) begin
      if (ce_i && push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (ce_i) begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule : spi_byte_fifo

// ### hw/spi_core.sv
`timescale 1ns/1ps
`include "spi_core_cfg.svh"
module spi_core import spi_core_pkg::*; #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   input  wire logic       ce_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [2:0] wb_adr_i,
   input  wire logic [7:0] wb_dat_i,
   output logic      [7:0] wb_dat_o,
   output logic            wb_ack_o,
   input  wire logic       sclk_i,
   output logic            sclk_o,
   output logic            sclk_oe_o,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe_o,
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe_o,
   output logic      [7:0] csn_o,
   input  wire logic       slave_select_n_i,
   input  wire logic       user_flash_select_n_i,
   input  wire logic [7:0] flash_tx_i,
   output logic      [7:0] flash_rx_o,
   output logic            flash_rx_valid_o,
   output logic            irq_o,
   output logic            stdby_o,
   output logic            wake_o
);

   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("spi_core: FIFO_DEPTH below 2 gives no double buffering");
   end

   // Next byte into the shifter, with the incoming bit at the far end
   function automatic logic [7:0] shift_byte(input logic [7:0] sh,
                                             input logic       b,
                                             input logic       lsb);
      shift_byte = lsb ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction : shift_byte

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   pins_t meta;
   pins_t pins;
   logic  sclk_prev;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         meta      <= pins_t'(`PINS_RST);
         pins      <= pins_t'(`PINS_RST);
         sclk_prev <= 1'b1;
      end else if (ce_i) begin
         meta      <= {sclk_i, mosi_i, miso_i, slave_select_n_i, user_flash_select_n_i};
         pins      <= meta;
         sclk_prev <= pins.sclk;
      end
   end

   // ----------------------------------------
   // Register state and WISHBONE decode
   // ----------------------------------------
   ctrl_t       ctrl;
   logic  [7:0] div;
   logic  [7:0] sel;
   logic        modf;
   logic        overrun;
   logic  [7:0] rx_data;
   logic        rx_full;
   xfer_state_t state;
   logic  [3:0] cnt;
   logic  [7:0] sh;
   logic        rx_bit;
   logic        to_flash;
   logic  [7:0] dcnt;

   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic       fifo_pop;

   logic wb_hit;
   logic wb_wr;
   logic wb_rd;
   logic tx_push;
   logic rx_pop;

   assign wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign tx_push = wb_hit & wb_we_i & (wb_adr_i == `ADR_DATA);
   // Full buffer holds the write off by withholding ack
   assign wb_wr   = wb_hit & wb_we_i & ~(tx_push & ~fifo_in_ready);
   assign wb_rd   = wb_hit & ~wb_we_i;
   assign rx_pop  = wb_rd & (wb_adr_i == `ADR_DATA);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end else if (ce_i) begin
         wb_ack_o <= wb_wr | wb_rd; // R12
         if (wb_rd) begin
            case (wb_adr_i)
               `ADR_CTRL: wb_dat_o <= {1'b0, ctrl};
               `ADR_DIV:  wb_dat_o <= div;
               `ADR_SEL:  wb_dat_o <= sel;
               `ADR_STAT: begin
                  wb_dat_o                 <= 8'h00;
                  wb_dat_o[`ST_TX_READY]   <= fifo_in_ready;
                  wb_dat_o[`ST_RX_FULL]    <= rx_full;
                  wb_dat_o[`ST_MODF]       <= modf; // R11
                  wb_dat_o[`ST_OVERRUN]    <= overrun;
                  wb_dat_o[`ST_BUSY]       <= (state != IDLE) | fifo_out_valid;
               end
               `ADR_DATA: wb_dat_o <= rx_data;
               default:   wb_dat_o <= 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ctrl <= ctrl_t'(`CTRL_RST);
         div  <= `DIV_RST;
         sel  <= `SEL_RST;
      end else if (ce_i && wb_wr) begin
         case (wb_adr_i)
            `ADR_CTRL: ctrl <= ctrl_t'(wb_dat_i[6:0]); // R1 R9 R10
            `ADR_DIV:  div  <= wb_dat_i;
            `ADR_SEL:  sel  <= wb_dat_i; // R6
            default:   ;
         endcase
      end
   end

   // ----------------------------------------
   // Transmit buffer
   // ----------------------------------------
   spi_byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .ce_i        (ce_i),
      .in_valid_i  (tx_push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (wb_dat_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   logic       master_mode;
   logic       slave_sel;
   logic       tick;
   logic       edge_p;
   logic       sample;
   logic       in_bit;
   logic       last;
   logic       start;
   logic       reload;
   logic [7:0] load_byte;
   logic [7:0] done_word;

   assign master_mode = ctrl.enable & ctrl.master & ~modf; // R15
   assign slave_sel   = ctrl.enable & ~ctrl.master & (~pins.scsn | ~pins.ufm_n); // R7 R8
   assign tick        = dcnt == div;
   assign edge_p      = (state == ACTIVE) &
                        (ctrl.master ? tick : (pins.sclk ^ sclk_prev)); // R2
   assign sample      = cnt[0] == ctrl.cpha; // R9
   assign in_bit      = ctrl.master ? pins.miso : pins.mosi; // R3 R4
   assign last        = edge_p & (cnt == `LAST_EDGE);
   assign done_word   = shift_byte(sh, sample ? in_bit : rx_bit, ctrl.lsb_first); // R14
   assign start       = (state == IDLE) &
                        ((master_mode & fifo_out_valid) | slave_sel);
   assign reload      = last & ~ctrl.master & slave_sel;
   // Slave without flash select and with nothing queued answers with an all-ones byte
   assign load_byte   = (~ctrl.master & ~pins.ufm_n) ? flash_tx_i :
                        fifo_out_valid ? fifo_out_data : `IDLE_BYTE;
   assign fifo_pop    = ce_i & (start | reload) & fifo_out_valid &
                        (ctrl.master | pins.ufm_n); // R14

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         dcnt <= 8'h00;
      end else if (ce_i) begin
         if (state == IDLE || tick) begin
            dcnt <= 8'h00;
         end else begin
            dcnt <= dcnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         state    <= IDLE;
         cnt      <= 4'h0;
         sh       <= 8'h00;
         rx_bit   <= 1'b0;
         to_flash <= 1'b0;
      end else if (ce_i) begin
         case (state)
            IDLE: begin
               if (start) begin
                  state    <= ACTIVE;
                  cnt      <= 4'h0;
                  sh       <= load_byte;
                  to_flash <= ~ctrl.master & ~pins.ufm_n; // R8
               end
            end
            ACTIVE: begin
               if (ctrl.master ? ~master_mode : ~slave_sel) begin
                  state <= IDLE; // R15
               end else if (reload) begin
                  cnt      <= 4'h0;
                  sh       <= load_byte;
                  to_flash <= ~pins.ufm_n;
               end else if (last) begin
                  state <= DONE;
               end else if (edge_p) begin
                  cnt <= cnt + 4'h1;
                  if (sample) begin
                     rx_bit <= in_bit; // R9
                  end else if (!(ctrl.cpha && cnt == 4'h0)) begin
                     sh <= shift_byte(sh, rx_bit, ctrl.lsb_first); // R10
                  end
               end
            end
            DONE: begin
               // Master keeps select low for one more half period
               if (!ctrl.master || tick || !master_mode) begin
                  state <= IDLE;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Received bytes and flags
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rx_data          <= 8'h00;
         rx_full          <= 1'b0;
         overrun          <= 1'b0;
         flash_rx_o       <= 8'h00;
         flash_rx_valid_o <= 1'b0;
      end else if (ce_i) begin
         flash_rx_valid_o <= 1'b0;
         if (rx_pop)
            rx_full <= 1'b0;
         if (wb_wr && wb_adr_i == `ADR_STAT && wb_dat_i[`ST_OVERRUN]) begin
            overrun <= 1'b0;
         end
         if (last && state == ACTIVE) begin
            if (to_flash) begin
               flash_rx_o       <= done_word; // R8
               flash_rx_valid_o <= 1'b1;
            end else begin
               rx_data <= done_word; // R14
               rx_full <= 1'b1;
               // Unread byte is overwritten; overrun tells software
               if (rx_full && !rx_pop) begin
                  overrun <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         modf  <= 1'b0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         // Set wins over a clear in the same cycle
         if (ctrl.enable && ctrl.master && !pins.scsn) begin
            modf <= 1'b1; // R15
         end else if (wb_wr && wb_adr_i == `ADR_STAT && wb_dat_i[`ST_MODF]) begin
            modf <= 1'b0;
         end
         irq_o <= modf & ctrl.irq_en; // R11
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         sclk_o    <= 1'b0;
         sclk_oe_o <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
         csn_o     <= 8'hff;
      end else if (ce_i) begin
         if (state == IDLE || !master_mode) begin
            sclk_o <= ctrl.cpol; // R9
         end else if (edge_p) begin
            sclk_o <= ~sclk_o; // R2
         end
         sclk_oe_o <= master_mode; // R2 R15
         mosi_o    <= ctrl.lsb_first ? sh[0] : sh[7];
         miso_o    <= ctrl.lsb_first ? sh[0] : sh[7];
         mosi_oe_o <= master_mode; // R4 R15
         miso_oe_o <= slave_sel; // R3
         if (start && master_mode) begin
            csn_o <= ~sel; // R5 R6
         end else if (!master_mode || (state == DONE && tick) || state == IDLE) begin
            csn_o <= 8'hff;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         stdby_o <= 1'b0;
         wake_o  <= 1'b0;
      end else if (ce_i) begin
         stdby_o <= wb_wr && wb_adr_i == `ADR_PWR && wb_dat_i[`PWR_STDBY] && ctrl.wake_en; // R13
         wake_o  <= wb_wr && wb_adr_i == `ADR_PWR && wb_dat_i[`PWR_WAKE] && ctrl.wake_en; // R13
      end
   end

endmodule : spi_core

// ### verif/spi_core_assertions.sv
`timescale 1ns/1ps
module spi_core_assertions (
   input wire logic       clk_sys_i,
   input wire logic       rst_b_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_we_i,
   input wire logic [2:0] wb_adr_i,
   input wire logic [7:0] wb_dat_i,
   input wire logic       wb_ack_o,
   input wire logic       sclk_oe_o,
   input wire logic       miso_oe_o,
   input wire logic       mosi_oe_o,
   input wire logic [7:0] csn_o,
   input wire logic       slave_select_n_i,
   input wire logic       user_flash_select_n_i,
   input wire logic       flash_rx_valid_o,
   input wire logic       irq_o,
   input wire logic       stdby_o,
   input wire logic       wake_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   a_ack_single_pulse: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
   a_ack_has_request: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_master_oe_pair: assert property (
      sclk_oe_o == mosi_oe_o) else $error("clock and data enables differ");
   a_clk_dir_excl: assert property (
      !(sclk_oe_o && miso_oe_o)) else $error("master and slave drive at once");
   a_fault_release: assert property (
      $fell(slave_select_n_i) && mosi_oe_o ##1 !slave_select_n_i [*4]
      |-> ##[0:2] (!mosi_oe_o && !sclk_oe_o && csn_o == 8'hff))
      else $error("lines still driven after mode fault");
   a_irq_clear: assert property (
      wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 3'h3 && $past(wb_dat_i[2])
      && $past(slave_select_n_i, 4) |-> ##[1:3] !irq_o)
      else $error("interrupt stays after fault clear");
   a_stdby_pulse: assert property (
      stdby_o |=> !stdby_o) else $error("standby request too long");
   a_pwr_from_write: assert property (
      (stdby_o || wake_o) |-> $past(wb_we_i) && $past(wb_adr_i) == 3'h5)
      else $error("power request without write");
   a_flash_pulse: assert property (
      flash_rx_valid_o |=> !flash_rx_valid_o) else $error("flash valid too long");
   a_flash_selected: assert property (
      flash_rx_valid_o |-> !$past(user_flash_select_n_i, 3))
      else $error("flash byte without flash select");
endmodule : spi_core_assertions

bind spi_core spi_core_assertions u_chk (.clk_sys_i, .rst_b_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .sclk_oe_o, .miso_oe_o, .mosi_oe_o,
   .csn_o, .slave_select_n_i, .user_flash_select_n_i, .flash_rx_valid_o, .irq_o,
   .stdby_o, .wake_o);

// ### verif/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model (
   input  wire logic       sclk_i,
   input  wire logic       csn_n_i,
   input  wire logic       mosi_i,
   input  wire logic       cpol_i,
   input  wire logic       cpha_i,
   input  wire logic       lsb_i,
   input  wire logic [7:0] tx_i,
   output logic            miso_o,
   output logic      [7:0] rx_o
);
   int idx;

   function automatic logic pick(input int i);
      pick = lsb_i ? tx_i[i] : tx_i[7-i];
   endfunction : pick

   initial miso_o = 1'b0;
   always @(negedge csn_n_i) begin
      idx = 0;
      if (!cpha_i) begin
         miso_o = pick(0);
         idx = 1;
      end
   end
   // No keeper on the line: show the inverse once released
   always @(posedge csn_n_i) miso_o = ~miso_o;
   always @(sclk_i) begin
      if (!csn_n_i) begin
         if ((sclk_i != cpol_i) ^ cpha_i)
            rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
         else if (idx < 8) begin
            miso_o = pick(idx);
            idx++;
         end
      end
   end
endmodule : spi_peer_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
   logic       clk_sys_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
   logic       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [2:0] wb_adr_i = 3'h0, md = 3'h0;
   logic [7:0] wb_dat_i = 8'h00, wb_dat_o, csn_o, flash_rx_o, ptx = 8'h00, prx, got;
   logic [7:0] flash_tx_i = 8'h00;
   logic       sclk_i = 1'b0, mosi_i = 1'b0, slave_select_n_i = 1'b1;
   logic       user_flash_select_n_i = 1'b1, sclk_o, sclk_oe_o, miso_o, miso_oe_o;
   logic       mosi_o, mosi_oe_o, flash_rx_valid_o, irq_o, stdby_o, wake_o;
   logic [1:0] pwr = 2'b00;
   wire logic  miso_i;
   int         err_count = 0;
   int         tests_run = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;

   spi_core dut (.clk_sys_i, .rst_b_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclk_i, .sclk_o, .sclk_oe_o, .miso_i, .miso_o,
      .miso_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .csn_o, .slave_select_n_i,
      .user_flash_select_n_i, .flash_tx_i, .flash_rx_o, .flash_rx_valid_o, .irq_o,
      .stdby_o, .wake_o);

   // Undriven lines float high through the board pull-ups
   spi_peer_model peer (.sclk_i(sclk_oe_o ? sclk_o : 1'b1), .csn_n_i(csn_o[0]),
      .mosi_i(mosi_oe_o ? mosi_o : 1'b1), .cpol_i(md[0]), .cpha_i(md[1]),
      .lsb_i(md[2]), .tx_i(ptx), .miso_o(miso_i), .rx_o(prx));

   always @(posedge clk_sys_i) begin
      if (flash_rx_valid_o)
         got <= flash_rx_o;
      pwr <= pwr | {stdby_o, wake_o};
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Bus access, entered at a falling edge
   // ----------------------------------------
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      wb_cyc_i = 1'b1;
      wb_stb_i = 1'b1;
      wb_we_i  = w;
      wb_adr_i = a;
      wb_dat_i = d;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 3000);
      if (n >= 3000)
         check("bus ack", 8'h00, 8'h01);
      q = wb_dat_o;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      @(negedge clk_sys_i);
   endtask : bus

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      bus(1'b0, a, 8'h00, q);
   endtask : rd

   task automatic poll_rx();
      logic [7:0] q;
      int n;
      n = 0;
      do begin
         rd(3'h3, q);
         n++;
      end while (q[1] !== 1'b1 && n < 200);
   endtask : poll_rx

   // External master, mode 0, msb first, 200 ns clock
   task automatic slave_xfer(input logic fl, input logic [7:0] d, output logic [7:0] q);
      if (fl)
         user_flash_select_n_i = 1'b0;
      else
         slave_select_n_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      for (int i = 7; i >= 0; i--) begin
         mosi_i = d[i];
         repeat (4) @(negedge clk_sys_i);
         sclk_i = 1'b1;
         q[i] = miso_o;
         repeat (4) @(negedge clk_sys_i);
         sclk_i = 1'b0;
      end
      repeat (8) @(negedge clk_sys_i);
      check("miso oe", {6'h0, miso_oe_o, sclk_oe_o}, 8'h02);
      slave_select_n_i = 1'b1;
      user_flash_select_n_i = 1'b1;
      mosi_i = ~mosi_i;
      repeat (8) @(negedge clk_sys_i);
   endtask : slave_xfer

   initial begin
      repeat (60000) @(posedge clk_sys_i);
      err_count++;
      finish_test();
   end

   initial begin
      logic [7:0] q;
      repeat (20) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      @(negedge clk_sys_i);
      check("reset csn", csn_o, 8'hff);
      check("reset oe", {5'h0, sclk_oe_o, miso_oe_o, mosi_oe_o}, 8'h00);
      rd(3'h0, q); check("ctrl", q, 8'h00);
      rd(3'h1, q); check("div", q, 8'h03);
      rd(3'h2, q); check("sel", q, 8'h01);
      rd(3'h3, q); check("stat", q, 8'h01);
      rd(3'h6, q); check("unmapped", q, 8'h00);
      wr(3'h1, 8'h05);
      rd(3'h1, q); check("div wr", q, 8'h05);
      for (int m = 0; m < 8; m++) begin
         md = 3'(m);
         ptx = 8'h96 ^ 8'(m);
         wr(3'h0, {3'b000, md, 2'b11});
         wr(3'h4, 8'(8'h5a + m));
         repeat (4) @(negedge clk_sys_i);
         check("csn", csn_o, 8'hfe);
         poll_rx();
         rd(3'h4, q); check("rx byte", q, ptx);
         check("peer byte", prx, 8'(8'h5a + m));
         check("sclk idle", {7'h0, sclk_o}, {7'h0, md[0]});
      end
      wr(3'h1, 8'h03);
      wr(3'h2, 8'h80);
      wr(3'h4, 8'h11);
      repeat (4) @(negedge clk_sys_i);
      check("csn top", csn_o, 8'h7f);
      // Frozen engine must hold the select well past a whole byte
      ce_i = 1'b0;
      repeat (300) @(negedge clk_sys_i);
      check("ce hold", csn_o, 8'h7f);
      ce_i = 1'b1;
      poll_rx();
      rd(3'h4, q);
      wr(3'h2, 8'h01);
      for (int m = 0; m < 5; m++)
         wr(3'h4, 8'(m));
      rd(3'h3, q); check("tx full", {7'h0, q[0]}, 8'h00);
      wr(3'h4, 8'h05);
      repeat (500) @(negedge clk_sys_i);
      rd(3'h3, q); check("overrun", q, 8'h0b);
      rd(3'h4, q); check("last rx", q, ptx);
      wr(3'h3, 8'h08);
      rd(3'h3, q); check("stat clr", q, 8'h01);
      md = 3'h0;
      wr(3'h0, 8'h23);
      slave_select_n_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      check("fault", {5'h0, sclk_oe_o, mosi_oe_o, irq_o}, 8'h01);
      slave_select_n_i = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      rd(3'h3, q); check("fault flag", q, 8'h05);
      wr(3'h3, 8'h04);
      repeat (3) @(negedge clk_sys_i);
      check("irq clr", {7'h0, irq_o}, 8'h00);
      wr(3'h0, 8'h01);
      wr(3'h4, 8'hc3);
      slave_xfer(1'b0, 8'h3e, q);
      check("slave tx", q, 8'hc3);
      rd(3'h4, q); check("slave rx", q, 8'h3e);
      flash_tx_i = 8'h69;
      slave_xfer(1'b1, 8'ha5, q);
      check("flash tx", q, 8'h69);
      check("flash rx", got, 8'ha5);
      rd(3'h3, q); check("flash apart", q, 8'h01);
      wr(3'h5, 8'h03);
      check("pwr off", {6'h0, pwr}, 8'h00);
      wr(3'h0, 8'h41);
      wr(3'h5, 8'h03);
      check("pwr on", {6'h0, pwr}, 8'h03);
      finish_test();
   end
endmodule : tb
